// >>> common/tcc_pkg.sv
// shared constants and types of the timer channel capture/compare block
`default_nettype none
package tcc_pkg;

   // ************************************************************
   // register map (byte wide, index = address)
   // ************************************************************
   localparam logic [1:0] TCC_ADDR_SC = 2'h0;
   localparam logic [1:0] TCC_ADDR_VH = 2'h1;
   localparam logic [1:0] TCC_ADDR_VL = 2'h2;

   // ************************************************************
   // channel_status_control field positions
   // ************************************************************
   localparam int TCC_FLAG_BIT = 7;
   localparam int TCC_IE_BIT   = 6;
   localparam int TCC_MSH_BIT  = 5;
   localparam int TCC_MSL_BIT  = 4;
   localparam int TCC_ELSH_BIT = 3;
   localparam int TCC_ELSL_BIT = 2;

   // ************************************************************
   // reset values and edge/level codes
   // ************************************************************
   localparam logic [15:0] TCC_VALUE_RESET = 16'h0000;
   localparam logic [7:0]  TCC_SC_RESET    = 8'h00;
   localparam logic [1:0]  TCC_ELS_OFF     = 2'h0;
   localparam logic [1:0]  TCC_ELS_01      = 2'h1;
   localparam logic [1:0]  TCC_ELS_10      = 2'h2;
   localparam logic [1:0]  TCC_ELS_11      = 2'h3;

   typedef enum logic [1:0]
   {
      TCC_MODE_CAPTURE,
      TCC_MODE_COMPARE,
      TCC_MODE_EPWM,
      TCC_MODE_CPWM
   } tcc_mode_t;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic tcc_mode_t tcc_mode_f(input logic cpwm,
                                            input logic msh,
                                            input logic msl);
      tcc_mode_t m;
      m = TCC_MODE_CAPTURE;
      if (cpwm)
         m = TCC_MODE_CPWM;
      else if (msh)
         m = TCC_MODE_EPWM;
      else if (msl)
         m = TCC_MODE_COMPARE;
      return m;
   endfunction

   // 0% duty at value zero, 100% once the value passes the modulo
   function automatic logic tcc_extreme_f(input logic [15:0] val,
                                          input logic [15:0] modulo);
      return (val == 16'h0000) || (val > modulo);
   endfunction

endpackage
`default_nettype wire

// >>> src/tcc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
`timescale 1ns/10ps
module tcc_pin_sync
   import tcc_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_pin,
   output logic      o_level
);

   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } tcc_sync_t;

   tcc_sync_t st_r;
   tcc_sync_t st_nxt;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = i_pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // s1 feeds only s2; a change counts once s2 and s3 agree
      if (st_r.s2 == st_r.s3)
         st_nxt.level = st_r.s3;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_level = st_r.level;

endmodule
`default_nettype wire

// >>> src/tcc_channel.sv
// one capture/compare/pwm channel of the timer pwm unit
//
// Function
// - capture edge sets channel event flag
// - counter match sets flag in compare/PWM
// - no flag at 0% or 100% PWM
// - interrupt when flag and enable set
// - clear by flag read then zero write
// - new event cancels pending clear
// - writing one no effect; reset clears flag
// - bit 6 is interrupt enable, reset zero
// - mode select high gives edge PWM
// - mode select low: capture or compare
// - edge/level bits pick edge/level/polarity
// - edge/level 00 releases pin
// - capture codes rise, fall, both
// - compare codes toggle, clear, set
// - edge PWM 10 high-true, X1 low-true
// - center PWM polarity on up match
//
// Chosen here: the plain strobed port and the register offsets.
`default_nettype none
`timescale 1ns/10ps
module tcc_channel
   import tcc_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic [1:0]       i_addr,
   input  wire logic [7:0]       i_wdata,
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   output logic      [7:0]       o_rdata,
   input  wire logic [CNT_W-1:0] i_counter,
   input  wire logic [CNT_W-1:0] i_modulo,
   input  wire logic             i_count_up,
   input  wire logic             i_center_pwm_select,
   input  wire logic             i_pin,
   output logic                  o_pin,
   output logic                  o_pin_oe,
   output logic                  o_irq
);

   // ************************************************************
   // elaboration check
   // ************************************************************
   if (CNT_W < 9 || CNT_W > 16)
   begin : g_bad_width
      $error("tcc_channel: CNT_W must lie in 9..16");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      logic             flag;
      logic             ie;
      logic             msh;
      logic             msl;
      logic [1:0]       els;
      logic             armed;
      logic             pin_out;
      logic             match_prev;
      logic             lvl_prev;
      logic [CNT_W-1:0] val;
      logic [7:0]       rdata;
   } tcc_state_t;

   tcc_state_t  st_r;
   tcc_state_t  st_nxt;

   logic        lvl;
   logic        sc_rd;
   logic        sc_wr;
   logic        rise;
   logic        fall;
   logic        match_now;
   logic        match_evt;
   logic        capture_evt;
   logic        compare_evt;
   logic        event_any;
   logic        pwm_mode;
   logic        extreme;
   logic        active_lvl;
   logic [15:0] val_ext;
   tcc_mode_t   mode;

   // ************************************************************
   // pin synchroniser
   // ************************************************************
   tcc_pin_sync u_sync
   (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_pin    (i_pin),
      .o_level  (lvl)
   );

   // ************************************************************
   // decode and events
   // ************************************************************
   // mode from center select and the two mode select bits
   assign mode = tcc_mode_f(i_center_pwm_select, st_r.msh, st_r.msl);

   assign pwm_mode  = (mode == TCC_MODE_EPWM) || (mode == TCC_MODE_CPWM);
   assign val_ext   = 16'(st_r.val);
   assign extreme   = tcc_extreme_f(val_ext, 16'(i_modulo));

   assign sc_rd = i_rd && (i_addr == TCC_ADDR_SC);
   assign sc_wr = i_wr && (i_addr == TCC_ADDR_SC);

   // edge on the filtered level only
   assign rise = lvl && !st_r.lvl_prev;
   assign fall = !lvl && st_r.lvl_prev;

   // capture edge choice per code, nothing at 00
   assign capture_evt = (mode == TCC_MODE_CAPTURE)
                        && ((st_r.els[0] && rise) || (st_r.els[1] && fall));

   // a match counts once, on the first cycle of equality
   assign match_now   = (i_counter == st_r.val);
   assign match_evt   = match_now && !st_r.match_prev;
   assign compare_evt = (mode != TCC_MODE_CAPTURE) && match_evt
                        && !(pwm_mode && extreme);

   assign event_any = capture_evt || compare_evt;

   // high-true for code 10, low-true for X1
   assign active_lvl = (st_r.els == TCC_ELS_10);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_nxt            = st_r;
      st_nxt.match_prev = match_now;
      st_nxt.lvl_prev   = lvl;
      st_nxt.rdata      = 8'h00;

      // register reads, answered one cycle later
      if (i_rd)
      begin
         unique case (i_addr)
            TCC_ADDR_SC:
               st_nxt.rdata = {st_r.flag, st_r.ie, st_r.msh, st_r.msl,
                               st_r.els, 2'h0};
            TCC_ADDR_VH:
               st_nxt.rdata = val_ext[15:8];
            TCC_ADDR_VL:
               st_nxt.rdata = val_ext[7:0];
            default:
               st_nxt.rdata = 8'h00;
         endcase
      end

      // a read of a set flag arms the clear
      if (sc_rd && st_r.flag)
         st_nxt.armed = 1'b1;

      if (sc_wr)
      begin
         st_nxt.ie  = i_wdata[TCC_IE_BIT];
         st_nxt.msh = i_wdata[TCC_MSH_BIT];
         st_nxt.msl = i_wdata[TCC_MSL_BIT];
         st_nxt.els = {i_wdata[TCC_ELSH_BIT], i_wdata[TCC_ELSL_BIT]};
         // writing one leaves the flag alone
         if (!i_wdata[TCC_FLAG_BIT] && st_r.armed)
            st_nxt.flag = 1'b0;
         st_nxt.armed = 1'b0;
      end

      if (i_wr && (i_addr == TCC_ADDR_VH))
         st_nxt.val = CNT_W'({i_wdata, val_ext[7:0]});
      if (i_wr && (i_addr == TCC_ADDR_VL))
         st_nxt.val = CNT_W'({val_ext[15:8], i_wdata});

      // capture beats a same-cycle software write of the value
      if (capture_evt)
         st_nxt.val = i_counter;

      // set wins over clear and drops any pending arm
      if (event_any)
      begin
         st_nxt.flag  = 1'b1;
         st_nxt.armed = 1'b0;
      end

      // pin output per mode
      unique case (mode)
         TCC_MODE_CAPTURE:
            st_nxt.pin_out = st_r.pin_out;
         TCC_MODE_COMPARE:
         begin
            if (match_evt)
            begin
               unique case (st_r.els)
                  TCC_ELS_01: st_nxt.pin_out = !st_r.pin_out;
                  TCC_ELS_10: st_nxt.pin_out = 1'b0;
                  TCC_ELS_11: st_nxt.pin_out = 1'b1;
                  TCC_ELS_OFF: st_nxt.pin_out = st_r.pin_out;
               endcase
            end
         end
         TCC_MODE_EPWM:
         begin
            if (val_ext == 16'h0000)
               st_nxt.pin_out = !active_lvl;
            else if (extreme)
               st_nxt.pin_out = active_lvl;
            else if (match_now)
               st_nxt.pin_out = !active_lvl;
            else if (i_counter == '0)
               st_nxt.pin_out = active_lvl;
         end
         TCC_MODE_CPWM:
         begin
            if (val_ext == 16'h0000)
               st_nxt.pin_out = !active_lvl;
            else if (extreme)
               st_nxt.pin_out = active_lvl;
            else if (match_evt)
               st_nxt.pin_out = i_count_up ? !active_lvl : active_lvl;
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_rdata = st_r.rdata;
   assign o_pin   = st_r.pin_out;
   // capture never drives; 00 hands the pin back to general I/O
   assign o_pin_oe = (mode != TCC_MODE_CAPTURE) && (st_r.els != TCC_ELS_OFF);
   assign o_irq    = st_r.flag && st_r.ie;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence seq_arm;
      sc_rd && st_r.flag && !event_any;
   endsequence

   sequence seq_zero_write;
      sc_wr && !i_wdata[TCC_FLAG_BIT] && !event_any;
   endsequence

   AST_CAPTURE_FLAG: assert property (
      capture_evt |=> st_r.flag && st_r.val == $past(i_counter))
      else $error("capture edge did not set flag and load value");

   AST_MATCH_FLAG: assert property (
      (mode == TCC_MODE_COMPARE) && match_now && !st_r.match_prev |=> st_r.flag)
      else $error("compare match did not set flag");

   AST_EXTREME_NOFLAG: assert property (
      pwm_mode && extreme && !st_r.flag && !capture_evt |=> !st_r.flag)
      else $error("flag set at 0 or 100 percent duty");

   AST_IRQ_FOLLOWS: assert property (
      event_any && st_r.ie && !sc_wr |=> o_irq)
      else $error("interrupt missing with flag and enable");

   AST_CLEAR_SEQ: assert property (
      seq_arm ##1 (!sc_wr && !event_any) ##1 seq_zero_write
      |=> !st_r.flag)
      else $error("read then zero write did not clear flag");

   AST_NO_CLEAR_UNARMED: assert property (
      $fell(st_r.flag) |-> $past(sc_wr && st_r.armed && !i_wdata[TCC_FLAG_BIT]))
      else $error("flag cleared without armed zero write");

   AST_CANCEL: assert property (
      st_r.armed && event_any |=> st_r.flag && !st_r.armed)
      else $error("event did not cancel pending clear");

   AST_WRITE_ONE: assert property (
      st_r.flag && sc_wr && i_wdata[TCC_FLAG_BIT] |=> st_r.flag)
      else $error("writing one changed the flag");

   AST_IE_WRITE: assert property (
      sc_wr |=> st_r.ie == $past(i_wdata[TCC_IE_BIT]))
      else $error("interrupt enable not stored");

   AST_PIN_RELEASE: assert property (
      st_r.els == TCC_ELS_OFF |-> !o_pin_oe)
      else $error("pin driven with edge/level 00");

endmodule
`default_nettype wire

// >>> test/tcc_pin_model.sv
// pin side model: the outside world sharing the channel pin
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model
(
   input  wire logic i_level,
   input  wire logic i_drive,
   input  wire logic i_drive_oe,
   output logic      o_wire
);
   // a released pin shows only the outside level
   assign o_wire = i_drive_oe ? i_drive : i_level;
endmodule
`default_nettype wire

// >>> test/timer_channel_capture_compare_bench.sv
// self-checking bench of the timer channel
`timescale 1ns/10ps
`default_nettype none
module timer_channel_capture_compare_bench import tcc_pkg::*;;
   typedef struct packed
   {
      logic [7:0] sc;
      logic [1:0] act;
      logic       fl;
      logic       pn;
      logic       oe;
   } tcc_row_t;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [1:0]  i_addr = 2'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_count_up = 1'b1;
   logic        i_center_pwm_select = 1'b0;
   logic        ext_level = 1'b0;
   logic [15:0] i_counter = 16'h00FF;
   logic [7:0]  o_rdata;
   logic        o_pin;
   logic        o_pin_oe;
   logic        o_irq;
   logic        pin_wire;
   int          errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   // act: 0 counter match, 1 pin to high, 2 pin to low
   tcc_row_t    rows [9] = '{
      '{8'h10, 2'h0, 1'b1, 1'b0, 1'b0}, '{8'h54, 2'h0, 1'b1, 1'b1, 1'b1},
      '{8'h18, 2'h0, 1'b1, 1'b0, 1'b1}, '{8'h5C, 2'h0, 1'b1, 1'b1, 1'b1},
      '{8'h44, 2'h1, 1'b1, 1'b0, 1'b0}, '{8'h08, 2'h2, 1'b1, 1'b0, 1'b0},
      '{8'h08, 2'h1, 1'b0, 1'b0, 1'b0}, '{8'h0C, 2'h2, 1'b1, 1'b0, 1'b0},
      '{8'h0C, 2'h1, 1'b1, 1'b0, 1'b0}};

   always #4 i_clk = ~i_clk;

   tcc_pin_model tcc_pin_model_inst
   (
      .i_level    (ext_level),
      .i_drive    (o_pin),
      .i_drive_oe (o_pin_oe),
      .o_wire     (pin_wire)
   );

   tcc_channel #(.CNT_W(16)) tcc_channel_inst
   (
      .i_clk               (i_clk),
      .i_resetn            (i_resetn),
      .i_addr              (i_addr),
      .i_wdata             (i_wdata),
      .i_wr                (i_wr),
      .i_rd                (i_rd),
      .o_rdata             (o_rdata),
      .i_counter           (i_counter),
      .i_modulo            (16'h0010),
      .i_count_up          (i_count_up),
      .i_center_pwm_select (i_center_pwm_select),
      .i_pin               (pin_wire),
      .o_pin               (o_pin),
      .o_pin_oe            (o_pin_oe),
      .o_irq               (o_irq)
   );

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk) i_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [1:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk) i_rd <= 1'b0;
      @(negedge i_clk) chk(o_rdata, e);
   endtask

   // counter parked off every value so byte writes cannot match
   task automatic setval(input logic [15:0] v);
      @(posedge i_clk) i_counter <= 16'h0100;
      wr(TCC_ADDR_VH, v[15:8]);
      wr(TCC_ADDR_VL, v[7:0]);
   endtask

   task automatic hit(input logic [15:0] v);
      @(posedge i_clk) i_counter <= 16'h00FF;
      @(posedge i_clk) i_counter <= v;
      cyc(3);
   endtask

   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         errors++;
         print_verdict();
      end
   end

   // ************************************************************
   // sequence
   // ************************************************************
   initial
   begin
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      cyc(1);
      rdc(TCC_ADDR_SC, TCC_SC_RESET);
      rdc(TCC_ADDR_VH, 8'h00);
      rdc(TCC_ADDR_VL, 8'h00);
      chk(o_irq, 1'b0);
      for (int i = 0; i < 9; i++)
      begin
         wr(TCC_ADDR_SC, rows[i].sc);
         if (rows[i].act == 2'h0)
         begin
            setval(16'h0005);
            hit(16'h0005);
         end
         else
         begin
            @(posedge i_clk) i_counter <= 16'h0033;
            // level moves two cycles after capture is armed
            @(posedge i_clk) ext_level <= rows[i].act[0];
            cyc(10);
         end
         chk(o_pin_oe, rows[i].oe);
         if (rows[i].oe) chk(o_pin, rows[i].pn);
         chk(o_irq, rows[i].fl & rows[i].sc[6]);
         rdc(TCC_ADDR_SC, {rows[i].fl, rows[i].sc[6:2], 2'b00});
         if (rows[i].act != 2'h0 && rows[i].fl)
         begin
            rdc(TCC_ADDR_VL, 8'h33);
            // read data stand one cycle only
            cyc(1);
            chk(o_rdata, 8'h00);
         end
         wr(TCC_ADDR_SC, rows[i].sc);
      end
      // clear sequence hazards; value set while still in capture
      setval(16'h0005);
      wr(TCC_ADDR_SC, 8'h50);
      hit(16'h0005);
      chk(o_irq, 1'b1);
      wr(TCC_ADDR_SC, 8'hD0);
      cyc(1);
      chk(o_irq, 1'b1);
      rdc(TCC_ADDR_SC, 8'hD0);
      hit(16'h0005);
      wr(TCC_ADDR_SC, 8'h50);
      cyc(1);
      chk(o_irq, 1'b1);
      wr(TCC_ADDR_SC, 8'h50);
      cyc(1);
      chk(o_irq, 1'b1);
      rdc(TCC_ADDR_SC, 8'hD0);
      wr(TCC_ADDR_SC, 8'h50);
      cyc(1);
      chk(o_irq, 1'b0);
      // edge pwm at 0% and 100%
      wr(TCC_ADDR_SC, 8'h68);
      setval(16'h0000);
      hit(16'h0000);
      chk(o_irq, 1'b0);
      chk(o_pin, 1'b0);
      setval(16'h0020);
      hit(16'h0020);
      chk(o_irq, 1'b0);
      chk(o_pin, 1'b1);
      // edge pwm polarity
      setval(16'h0005);
      @(posedge i_clk) i_counter <= 16'h0000;
      cyc(3);
      chk(o_pin, 1'b1);
      hit(16'h0005);
      chk(o_pin, 1'b0);
      chk(o_irq, 1'b1);
      wr(TCC_ADDR_SC, 8'h64);
      @(posedge i_clk) i_counter <= 16'h0000;
      cyc(3);
      chk(o_pin, 1'b0);
      hit(16'h0005);
      chk(o_pin, 1'b1);
      // center pwm, up then down match
      @(posedge i_clk) i_center_pwm_select <= 1'b1;
      wr(TCC_ADDR_SC, 8'h48);
      hit(16'h0005);
      chk(o_pin, 1'b0);
      @(posedge i_clk) i_count_up <= 1'b0;
      hit(16'h0005);
      chk(o_pin, 1'b1);
      wr(2'h3, 8'hFF);
      rdc(2'h3, 8'h00);
      rdc(TCC_ADDR_SC, 8'hC8);
      // reset in mid-run with the flag set
      @(posedge i_clk) i_resetn <= 1'b0;
      cyc(2);
      @(posedge i_clk) i_resetn <= 1'b1;
      rdc(TCC_ADDR_SC, TCC_SC_RESET);
      chk(o_pin_oe, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
